// *** design/setr_target.sv ***
// Purpose: Two-wire serial memory target with current, random and sequential read.
// Assumes: Bus clock and data pins are far slower than clock_in and are synchronised.
// Notes: Received write bytes pass a FIFO before they reach the array.
//
// Function
// [RULE1] Read begins like write, direction bit one.
// [RULE2] Current, random and sequential reads are supported.
// [RULE3] Counter holds last accessed location plus one.
// [RULE4] Counter kept between transactions, never cleared.
// [RULE5] Read increment wraps top to address zero.
// [RULE6] Write increment wraps within the same page.
// [RULE7] After read address ack, send byte MSB first.
// [RULE8] Controller ends single read with no-ack, stop.
// [RULE9] Controller loads address with a dummy write.
// [RULE10] Controller restarts and resends address with read.
// [RULE11] Acknowledge repeated address, send newly loaded byte.
// [RULE12] Controller ack after each byte continues reading.
// [RULE13] Each acked byte increments address, sends next.
// [RULE14] Sequential read wraps to bottom without pause.
// [RULE15] Controller ends sequential read with no-ack, stop.
// [RULE16] Start and stop are data edges while clock high.
// [RULE17] Eight-bit words, target pulls low on ninth clock.
// [RULE18] Address byte: type, strap or page, direction.
// [RULE19] Mismatched address gets no ack, back to idle.
// [RULE20] Release data line in read acknowledge slot.
`timescale 1ns/1ps

module setr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Filling side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign in_ready_out = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid_out = wp_r != rp_r;
  assign out_data_out = mem[rp_r[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data_in;
    end
  end
endmodule

module setr_target (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Straps
  input wire logic [2:0] strap_address_pins_in
);
  import setr_pkg::*;

  logic [SYNC_W-1:0] meta_r, sync_r, prev_r;
  logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
  logic [2:0] strap_s;
  setr_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [ADDR_W-1:0] ptr_r, ptr_nxt;
  logic [PSEL_W-1:0] pg_r, pg_nxt;
  logic drv_r, drv_nxt, rw_r, rw_nxt, ackd_r, ackd_nxt;
  logic push, push_rdy, drain_vld, drain_rdy, match;
  logic [ADDR_W+7:0] drain_data;
  logic [7:0] arr [2**ADDR_W];
  logic [7:0] mem_q;

  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] strap);
    dev_match = (b[7:4] == TYPE_ID) && (((b[3:1] ^ strap) & STRAP_MASK) == 3'h0);
  endfunction

  function automatic logic [ADDR_W-1:0] wr_inc(input logic [ADDR_W-1:0] a);
    wr_inc = {a[ADDR_W-1:PAGE_W], PAGE_W'(a[PAGE_W-1:0] + 1'b1)};
  endfunction

  // Only the second stage and the edge history are read by logic.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= {SYNC_W{1'b1}};
      sync_r <= {SYNC_W{1'b1}};
      prev_r <= {SYNC_W{1'b1}};
    end else begin
      meta_r <= {strap_address_pins_in, sda_in, scl_in};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign scl_s = sync_r[0];
  assign sda_s = sync_r[1];
  assign strap_s = sync_r[4:2];
  assign scl_rise = scl_s && !prev_r[0];
  assign scl_fall = !scl_s && prev_r[0];
  assign start_ev = scl_s && prev_r[0] && !sda_s && prev_r[1]; // RULE16
  assign stop_ev = scl_s && prev_r[0] && sda_s && !prev_r[1]; // RULE16
  assign match = dev_match(sh_r, strap_s); // RULE18
  assign sda_out = 1'b0;
  assign sda_oe_n_out = !drv_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    pg_nxt = pg_r;
    drv_nxt = drv_r;
    rw_nxt = rw_r;
    ackd_nxt = ackd_r;
    push = 1'b0;
    if (start_ev) begin
      state_nxt = ST_DEV;
      cnt_nxt = 4'h0;
      drv_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt = ST_IDLE;
      drv_nxt = 1'b0;
    end else if (scl_rise) begin
      if (state_r == ST_DEV || state_r == ST_WADDR || state_r == ST_WDATA) begin
        sh_nxt = {sh_r[6:0], sda_s};
        cnt_nxt = cnt_r + 4'h1;
      end else if (state_r == ST_RACK) begin
        ackd_nxt = !sda_s; // RULE12
      end
    end else if (scl_fall) begin
      unique case (state_r)
        ST_IDLE: begin
          drv_nxt = 1'b0;
        end
        ST_DEV: begin
          if (cnt_r == BITS_PER_WORD) begin
            if (match) begin
              drv_nxt = 1'b1; // RULE17
              rw_nxt = sh_r[0]; // RULE1
              pg_nxt = sh_r[3:1];
              state_nxt = ST_DEV_ACK;
            end else begin
              state_nxt = ST_IDLE; // RULE19
            end
          end
        end
        ST_DEV_ACK, ST_RACK: begin
          if (state_r == ST_RACK && !ackd_r) begin
            drv_nxt = 1'b0;
            state_nxt = ST_IDLE;
          end else if (state_r == ST_DEV_ACK && !rw_r) begin
            drv_nxt = 1'b0;
            cnt_nxt = 4'h0;
            state_nxt = ST_WADDR;
          end else begin
            // Current position byte goes out first; counter moves past it.
            sh_nxt = mem_q; // RULE2 RULE7 RULE11
            drv_nxt = !mem_q[7]; // RULE7
            ptr_nxt = ptr_r + 1'b1; // RULE3 RULE5 RULE13 RULE14
            cnt_nxt = 4'h1;
            state_nxt = ST_RDATA;
          end
        end
        ST_WADDR: begin
          if (cnt_r == BITS_PER_WORD) begin
            drv_nxt = 1'b1; // RULE17
            ptr_nxt = {pg_r, sh_r}; // RULE11
            state_nxt = ST_WADDR_ACK;
          end
        end
        ST_WADDR_ACK, ST_WDATA_ACK: begin
          drv_nxt = 1'b0;
          cnt_nxt = 4'h0;
          state_nxt = ST_WDATA;
        end
        ST_WDATA: begin
          if (cnt_r == BITS_PER_WORD) begin
            // A full FIFO refuses the byte with a missing acknowledge.
            if (push_rdy) begin
              push = 1'b1;
              drv_nxt = 1'b1; // RULE17
              ptr_nxt = wr_inc(ptr_r); // RULE6
              state_nxt = ST_WDATA_ACK;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_RDATA: begin
          if (cnt_r == BITS_PER_WORD) begin
            drv_nxt = 1'b0; // RULE20
            ackd_nxt = 1'b0;
            state_nxt = ST_RACK;
          end else begin
            drv_nxt = !sh_r[6]; // RULE7
            sh_nxt = {sh_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        default: begin
          drv_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // The counter has no clear besides power-on reset.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= '0; // RULE4
      pg_r <= '0;
      drv_r <= 1'b0;
      rw_r <= 1'b0;
      ackd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      pg_r <= pg_nxt;
      drv_r <= drv_nxt;
      rw_r <= rw_nxt;
      ackd_r <= ackd_nxt;
    end
  end

  // Writes commit only while no read byte is being shifted out.
  assign drain_rdy = (state_r != ST_RDATA);

  setr_fifo #(.WIDTH(ADDR_W + 8), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push),
    .in_ready_out(push_rdy),
    .in_data_in({ptr_r, sh_r}),
    .out_valid_out(drain_vld),
    .out_ready_in(drain_rdy),
    .out_data_out(drain_data)
  );

  always_ff @(posedge clock_in) begin
    if (drain_vld && drain_rdy) begin
      arr[drain_data[ADDR_W+7:8]] <= drain_data[7:0];
    end
    mem_q <= arr[ptr_r];
  end

  logic rd_load;
  assign rd_load = scl_fall && !start_ev && !stop_ev &&
                   ((state_r == ST_DEV_ACK && rw_r) || (state_r == ST_RACK && ackd_r));

  ack_match_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE17
    scl_fall && !start_ev && !stop_ev && state_r == ST_DEV && cnt_r == 4'h8 && match
    |=> drv_r && state_r == ST_DEV_ACK)
    else $error("Matching address not acknowledged.");
  nack_miss_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE19
    scl_fall && !start_ev && !stop_ev && state_r == ST_DEV && cnt_r == 4'h8 && !match
    |=> !drv_r && state_r == ST_IDLE)
    else $error("Mismatched address was not ignored.");
  read_wrap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE5
    rd_load && ptr_r == {ADDR_W{1'b1}} |=> ptr_r == '0)
    else $error("Read counter did not wrap to zero.");
  page_wrap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE6
    push |=> ptr_r[PAGE_W-1:0] == $past(ptr_r[PAGE_W-1:0]) + 4'h1 &&
    ptr_r[ADDR_W-1:PAGE_W] == $past(ptr_r[ADDR_W-1:PAGE_W]))
    else $error("Write counter left its page.");
  msb_first_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE7
    rd_load |=> drv_r == !$past(mem_q[7]) && state_r == ST_RDATA)
    else $error("First read bit is not the MSB.");
  ack_release_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE20
    state_r == ST_RACK |-> !drv_r)
    else $error("Data line driven in read acknowledge slot.");
  ptr_keep_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE4
    state_r == ST_IDLE && !start_ev |=> $stable(ptr_r))
    else $error("Counter changed while idle.");
  start_seen_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE16
    start_ev |=> state_r == ST_DEV && cnt_r == 4'h0 && !drv_r)
    else $error("Start condition not taken.");
  seq_step_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE13
    rd_load |=> ptr_r == $past(ptr_r) + 1'b1 ##1 (cnt_r == 4'h1)[*2])
    else $error("Sequential read did not advance.");
  rand_load_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RULE11
    scl_fall && !start_ev && !stop_ev && state_r == ST_WADDR && cnt_r == 4'h8
    |=> ptr_r == {$past(pg_r), $past(sh_r)})
    else $error("Word address not loaded.");

  seq_read_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state_r == ST_RACK && ackd_r && scl_fall);
  rand_read_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state_r == ST_WADDR_ACK ##[1:1000] start_ev);
  wrap_read_c: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    rd_load && ptr_r == {ADDR_W{1'b1}});
  fifo_full_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) !push_rdy);
endmodule

// *** inc/setr_pkg.sv ***
// Purpose: Shared constants and types of the serial memory read target.
// Assumes: Largest array organisation, page bits taken from the address byte.
// Notes: Memory content is not reset; only control state is.
package setr_pkg;
  localparam int PSEL_W = 3;
  localparam int ADDR_W = PSEL_W + 8;
  localparam int PAGE_W = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_W = 5;
  localparam logic [3:0] TYPE_ID = 4'ha;
  localparam logic [2:0] STRAP_MASK = 3'h0;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  localparam real CLK_PERIOD_NS = 50.0;
  localparam real LINK_PERIOD_NS = 400.0;
  localparam int LINK_CYCLES = int'(LINK_PERIOD_NS / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h2,
    ST_WADDR = 4'h3,
    ST_WADDR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } setr_state_t;
endpackage

// *** sim/setr_ctrl_model.sv ***
// Purpose: Behavioural two-wire bus controller that drives the serial memory target.
// Assumes: Bus line is pulled up, so driving one means releasing the data line.
// Notes: Clock stands high between frames; every bit is 5 clocks low and 3 clocks high.
`timescale 1ns/1ps

module setr_ctrl_model (
  // Clock and resolved data line
  input wire logic clock_in,
  input wire logic sda_in,
  // Driven bus lines
  output logic scl_out,
  output logic sda_drv_out
);
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // Data moves two clocks into the low phase, leaving three clocks of setup before the rise.
  task automatic put_bit(input logic b, output logic seen);
    wait_clk(2);
    sda_drv_out = b;
    wait_clk(3);
    scl_out = 1'b1;
    wait_clk(1);
    seen = sda_in;
    wait_clk(2);
    scl_out = 1'b0;
  endtask

  task automatic start_cond();
    wait_clk(2);
    sda_drv_out = 1'b1;
    wait_clk(3);
    scl_out = 1'b1;
    wait_clk(3);
    sda_drv_out = 1'b0;
    wait_clk(3);
    scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    wait_clk(2);
    sda_drv_out = 1'b0;
    wait_clk(3);
    scl_out = 1'b1;
    wait_clk(3);
    sda_drv_out = 1'b1;
    wait_clk(4);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, ack);
  endtask

  // A low acknowledge asks for one more byte; a high one ends the read.
  task automatic recv_byte(input logic more, output logic [7:0] v, output logic slot);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, v[i]);
    end
    put_bit(~more, slot);
  endtask
endmodule

// *** sim/test_setr_target.sv ***
// Purpose: Self-checking bench for the read side of the serial memory target.
// Assumes: Array content is unknown until written, so every read targets written bytes.
// Notes: Strap pins are tied; the target ignores them under its zero compare mask.
`timescale 1ns/1ps

module test_setr_target;
  import setr_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda;
  logic sda_out;
  logic sda_oe_n_out;
  logic [2:0] strap = 3'h5;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;

  assign sda = sda_drv & (sda_oe_n_out | sda_out);
  always #25 clock_in = ~clock_in;

  setr_target uut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out),
    .strap_address_pins_in(strap)
  );

  setr_ctrl_model ctrl (
    .clock_in(clock_in),
    .sda_in(sda),
    .scl_out(scl),
    .sda_drv_out(sda_drv)
  );

  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Loads the counter through a write header; the repeated start that follows makes it a dummy write.
  task automatic addr_phase(input logic [10:0] a);
    logic k;
    ctrl.start_cond();
    ctrl.send_byte({TYPE_ID, a[10:8], 1'b0}, k);
    check("device ack", 8'h00, {7'h0, k});
    ctrl.send_byte(a[7:0], k);
    check("word ack", 8'h00, {7'h0, k});
  endtask

  task automatic t_write(input logic [10:0] a, input logic [7:0] d[$]);
    logic k;
    addr_phase(a);
    foreach (d[i]) begin
      ctrl.send_byte(d[i], k);
      check("data ack", 8'h00, {7'h0, k});
    end
    ctrl.stop_cond();
    ctrl.wait_clk(20);
  endtask

  task automatic t_read(input logic [2:0] pg, input logic [7:0] exp[$]);
    logic k;
    logic [7:0] v;
    ctrl.start_cond();
    ctrl.send_byte({TYPE_ID, pg, 1'b1}, k);
    check("read ack", 8'h00, {7'h0, k});
    foreach (exp[i]) begin
      ctrl.recv_byte(i < exp.size() - 1, v, k);
      check("read data", exp[i], v);
    end
    check("nack slot", 8'h01, {7'h0, k});
    ctrl.stop_cond();
    ctrl.wait_clk(10);
  endtask

  // Four bytes from the next-to-last address wrap inside the top page.
  task automatic t_page_wrap();
    t_write(11'h000, {8'h5a, 8'h3c});
    t_write(11'h7fe, {8'h81, 8'h42, 8'hc3, 8'h24});
    addr_phase(11'h7f0);
    t_read(3'h7, {8'hc3, 8'h24});
  endtask

  task automatic t_seq_wrap();
    addr_phase(11'h7fe);
    t_read(3'h7, {8'h81, 8'h42, 8'h5a});
  endtask

  // A foreign type pattern must be ignored and must not move the counter.
  task automatic t_mismatch();
    logic k;
    logic [7:0] v;
    ctrl.start_cond();
    ctrl.send_byte({4'hb, 3'h0, 1'b1}, k);
    check("foreign ack", 8'h01, {7'h0, k});
    ctrl.recv_byte(1'b0, v, k);
    check("idle line", 8'hff, v);
    ctrl.stop_cond();
  endtask

  task automatic t_current();
    t_read(3'h0, {8'h3c});
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("Error timeout expected done seen running");
      final_report();
    end
  end

  initial begin
    repeat (4) @(negedge clock_in);
    rst_n_in = 1'b1;
    ctrl.wait_clk(4);
    t_page_wrap();
    t_seq_wrap();
    t_mismatch();
    t_current();
    final_report();
  end
endmodule
